// [design/haw_pkg.sv]
// constants, types and carriers for the host attention and wake handshake block
// assumes a 200 MHz core clock; all pins arrive unsynchronised
// What this block does
// - spi link: four wires, device is slave, clock idles high, sample on rise
// - host side two-wire port is an addressed slave
// - in spi and i2c modes attention is raised whenever service is needed
// - attention is active low, held until own i2c address ends or chip select seen
// - in uart mode readiness after startup is an advertisement message
// - asleep device woken by wake input, then in spi and i2c modes raises attention, about 150 us
// - in uart mode attention leads each transmission by about 7.7 us
// - in uart mode attention is released before transmission ends
package haw_pkg;
  localparam int CLK_PS = 5000;
  localparam int LEAD_NS = 7700;
  localparam int LEAD_CYC = (LEAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int GAP_NS = 1000;
  localparam int GAP_CYC = (GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WAKE_US = 150;
  localparam int WAKE_CYC_DEF = (WAKE_US * 1000000) / CLK_PS;
  localparam int BOOT_MS = 90;
  localparam int BOOT_CYC_DEF = (BOOT_MS * 1000000) / (CLK_PS / 1000);
  localparam int BAUD_RATE = 115200;
  localparam int BAUD_DIV = (1000000000 / (CLK_PS / 1000)) / BAUD_RATE;
  localparam int TMR_W = 25;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;
  localparam logic [3:0] UART_STOP_IDX = 4'h9;
  localparam logic [3:0] I2C_ADDR_BITS = 4'h8;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam logic [7:0] SPI_FILL = 8'h00;
  // arbitrary value, no maker meaning
  localparam logic [7:0] ADV_BYTE_DEF = 8'ha5;
  // arbitrary value
  localparam logic [6:0] I2C_ADDR_DEF = 7'h2c;

  typedef logic [TMR_W-1:0] haw_tmr_t;
  typedef logic [7:0] haw_gap_t;

  typedef enum logic [1:0] {
    MODE_I2C = 2'b00,
    MODE_SPI = 2'b01,
    MODE_UART = 2'b10,
    MODE_RSVD = 2'b11
  } haw_mode_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b011,
    ST_LEAD = 3'b100,
    ST_SEND = 3'b101
  } haw_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wake_n;
    logic [1:0] mode;
  } haw_pins_t;

  localparam haw_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, sclk: 1'b1, cs_n: 1'b1,
                                      mosi: 1'b1, wake_n: 1'b1, mode: 2'b00};
endpackage

// [design/haw_top.sv]
// outgoing byte fifo and the host attention, wake and link framing logic
// assumes pins are asynchronous to I_CLK; user side ports are on I_CLK
`timescale 1ns/1ps

module haw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q, ready_d, valid_q, valid_d;
  logic push, pop;

  always_comb begin
    push = i_in_valid & ready_q;
    pop = i_out_ready & valid_q;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
    ready_d = cnt_d != FULL_CNT;
    valid_d = cnt_d != '0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready = ready_q;
  assign o_out_valid = valid_q;
  assign o_out_data = mem_q[rd_q];
endmodule

module haw_top #(
  parameter int BOOT_CYC = haw_pkg::BOOT_CYC_DEF,
  parameter int WAKE_CYC = haw_pkg::WAKE_CYC_DEF,
  parameter logic [6:0] I2C_ADDR = haw_pkg::I2C_ADDR_DEF,
  parameter logic [7:0] ADV_BYTE = haw_pkg::ADV_BYTE_DEF
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [1:0] I_MODE,
  input wire logic I_WAKE_N,
  input wire logic I_SLEEP,
  input wire logic I_TX_VALID,
  input wire logic [7:0] I_TX_DATA,
  output logic O_TX_READY,
  input wire logic I_SPI_SCLK,
  input wire logic I_SPI_CS_N,
  input wire logic I_SPI_MOSI,
  output logic O_SPI_MISO,
  output logic O_SPI_MISO_OE_N,
  output logic O_RX_VALID,
  output logic [7:0] O_RX_DATA,
  input wire logic I_I2C_SCL,
  input wire logic I_I2C_SDA,
  output logic O_I2C_SDA,
  output logic O_I2C_SDA_OE_N,
  output logic O_UART_TX,
  output logic O_AWAKE,
  output logic O_HOST_ATTENTION_N
);
  localparam haw_pkg::haw_tmr_t BOOT_END = haw_pkg::haw_tmr_t'(BOOT_CYC - 1);
  localparam haw_pkg::haw_tmr_t WAKE_END = haw_pkg::haw_tmr_t'(WAKE_CYC - 1);
  localparam haw_pkg::haw_tmr_t LEAD_END = haw_pkg::haw_tmr_t'(haw_pkg::LEAD_CYC - 1);
  localparam haw_pkg::haw_tmr_t BAUD_END = haw_pkg::haw_tmr_t'(haw_pkg::BAUD_DIV - 1);
  localparam haw_pkg::haw_gap_t GAP_END = haw_pkg::haw_gap_t'(haw_pkg::GAP_CYC);

  haw_pkg::haw_pins_t pins_raw, s1_q, s2_q, pv_q;
  logic fifo_ready, fifo_valid, fifo_pop, pop_u, pop_s;
  logic [7:0] fifo_data;
  logic push_w;

  // two-stage synchroniser, then one more stage only for edge finding
  assign pins_raw = '{scl: I_I2C_SCL, sda: I_I2C_SDA, sclk: I_SPI_SCLK, cs_n: I_SPI_CS_N,
                      mosi: I_SPI_MOSI, wake_n: I_WAKE_N, mode: I_MODE};

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      s1_q <= haw_pkg::PINS_IDLE;
      s2_q <= haw_pkg::PINS_IDLE;
      pv_q <= haw_pkg::PINS_IDLE;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      pv_q <= s2_q;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, scl_rise, scl_fall, i2c_start, i2c_stop;
  assign sclk_rise = s2_q.sclk & ~pv_q.sclk;
  assign sclk_fall = ~s2_q.sclk & pv_q.sclk;
  assign cs_fall = ~s2_q.cs_n & pv_q.cs_n;
  assign scl_rise = s2_q.scl & ~pv_q.scl;
  assign scl_fall = ~s2_q.scl & pv_q.scl;
  assign i2c_start = pv_q.sda & ~s2_q.sda & s2_q.scl & pv_q.scl;
  assign i2c_stop = ~pv_q.sda & s2_q.sda & s2_q.scl & pv_q.scl;

  assign fifo_pop = pop_u | pop_s;
  assign push_w = I_TX_VALID & fifo_ready;

  haw_fifo #(
    .WIDTH(haw_pkg::FIFO_W),
    .DEPTH(haw_pkg::FIFO_D)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_in_valid(I_TX_VALID),
    .i_in_data(I_TX_DATA),
    .o_in_ready(fifo_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(fifo_pop)
  );

  // main sequencer: boot, sleep and wake, uart framing
  haw_pkg::haw_state_t state_q, state_d;
  haw_pkg::haw_mode_t mode_q, mode_d;
  haw_pkg::haw_tmr_t tmr_q, tmr_d;
  logic [9:0] ush_q, ush_d;
  logic [3:0] ubit_q, ubit_d;
  logic uattn_q, uattn_d, adv_q, adv_d, tx_q, tx_d, awake_q, awake_d, fire_ev;
  logic gap_ok;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    tmr_d = tmr_q + 1'b1;
    ush_d = ush_q;
    ubit_d = ubit_q;
    uattn_d = uattn_q;
    adv_d = adv_q;
    tx_d = 1'b1;
    awake_d = awake_q;
    fire_ev = 1'b0;
    pop_u = 1'b0;
    case (state_q)
      haw_pkg::ST_BOOT: begin
        // mode strap is caught while booting, after reset release
        mode_d = haw_pkg::haw_mode_t'(s2_q.mode);
        if (tmr_q == BOOT_END) begin
          state_d = haw_pkg::ST_IDLE;
          awake_d = 1'b1;
          fire_ev = mode_q != haw_pkg::MODE_UART;
        end
      end
      haw_pkg::ST_IDLE: begin
        tmr_d = '0;
        if (mode_q == haw_pkg::MODE_UART && (!adv_q || fifo_valid) && gap_ok) begin
          // readiness in uart mode is the advertisement byte, sent first
          ush_d = {1'b1, adv_q ? fifo_data : ADV_BYTE, 1'b0};
          pop_u = adv_q;
          adv_d = 1'b1;
          uattn_d = 1'b1;
          ubit_d = '0;
          state_d = haw_pkg::ST_LEAD;
        end else if (I_SLEEP && !fifo_valid) begin
          awake_d = 1'b0;
          state_d = haw_pkg::ST_SLEEP;
        end
      end
      haw_pkg::ST_SLEEP: begin
        tmr_d = '0;
        if (!s2_q.wake_n) begin
          state_d = haw_pkg::ST_WAKE;
        end
      end
      haw_pkg::ST_WAKE: begin
        if (tmr_q == WAKE_END) begin
          state_d = haw_pkg::ST_IDLE;
          awake_d = 1'b1;
          fire_ev = mode_q != haw_pkg::MODE_UART;
        end
      end
      haw_pkg::ST_LEAD: begin
        // no flow control: the host is assumed always able to receive
        if (tmr_q == LEAD_END) begin
          tmr_d = '0;
          state_d = haw_pkg::ST_SEND;
        end
      end
      haw_pkg::ST_SEND: begin
        tx_d = ush_q[0];
        if (tmr_q == BAUD_END) begin
          tmr_d = '0;
          ush_d = {1'b1, ush_q[9:1]};
          ubit_d = ubit_q + 1'b1;
          tx_d = ush_q[1];
          if (ubit_q + 1'b1 == haw_pkg::UART_STOP_IDX) begin
            uattn_d = 1'b0;
          end
          if (ubit_q == haw_pkg::UART_STOP_IDX) begin
            tx_d = 1'b1;
            state_d = haw_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = haw_pkg::ST_BOOT;
        tmr_d = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_q <= haw_pkg::ST_BOOT;
      mode_q <= haw_pkg::MODE_I2C;
      tmr_q <= '0;
      ush_q <= '1;
      ubit_q <= '0;
      uattn_q <= 1'b0;
      adv_q <= 1'b0;
      tx_q <= 1'b1;
      awake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      tmr_q <= tmr_d;
      ush_q <= ush_d;
      ubit_q <= ubit_d;
      uattn_q <= uattn_d;
      adv_q <= adv_d;
      tx_q <= tx_d;
      awake_q <= awake_d;
    end
  end

  // spi slave, clock idles high, sample on rise, drive on fall
  logic [7:0] rsh_q, rsh_d, tsh_q, tsh_d, rxd_q, rxd_d;
  logic [2:0] sbit_q, sbit_d;
  logic miso_q, miso_d, moe_n_q, moe_n_d, rxv_q, rxv_d, cs_seen;

  always_comb begin
    rsh_d = rsh_q;
    tsh_d = tsh_q;
    rxd_d = rxd_q;
    sbit_d = sbit_q;
    miso_d = miso_q;
    moe_n_d = 1'b1;
    rxv_d = 1'b0;
    pop_s = 1'b0;
    cs_seen = 1'b0;
    if (mode_q != haw_pkg::MODE_SPI || s2_q.cs_n || state_q == haw_pkg::ST_BOOT) begin
      sbit_d = '0;
    end else begin
      moe_n_d = 1'b0;
      cs_seen = cs_fall;
      if (sclk_fall) begin
        miso_d = tsh_q[7];
        tsh_d = {tsh_q[6:0], 1'b0};
      end
      if (sclk_rise) begin
        rsh_d = {rsh_q[6:0], s2_q.mosi};
        sbit_d = sbit_q + 1'b1;
      end
      // a fresh byte is loaded at select and after every eighth rise
      if (cs_fall || (sclk_rise && sbit_q == haw_pkg::SPI_LAST_BIT)) begin
        tsh_d = fifo_valid ? fifo_data : haw_pkg::SPI_FILL;
        pop_s = fifo_valid;
      end
      if (sclk_rise && sbit_q == haw_pkg::SPI_LAST_BIT) begin
        rxv_d = 1'b1;
        rxd_d = {rsh_q[6:0], s2_q.mosi};
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      rsh_q <= '0;
      tsh_q <= '0;
      rxd_q <= '0;
      sbit_q <= '0;
      miso_q <= 1'b0;
      moe_n_q <= 1'b1;
      rxv_q <= 1'b0;
    end else begin
      rsh_q <= rsh_d;
      tsh_q <= tsh_d;
      rxd_q <= rxd_d;
      sbit_q <= sbit_d;
      miso_q <= miso_d;
      moe_n_q <= moe_n_d;
      rxv_q <= rxv_d;
    end
  end

  // i2c slave address recognition; the data phase is left to other logic
  logic [7:0] ish_q, ish_d;
  logic [3:0] ibit_q, ibit_d;
  logic iact_q, iact_d, ackp_q, ackp_d, sdoe_n_q, sdoe_n_d, addr_hit;

  always_comb begin
    ish_d = ish_q;
    ibit_d = ibit_q;
    iact_d = iact_q;
    ackp_d = ackp_q;
    sdoe_n_d = sdoe_n_q;
    addr_hit = 1'b0;
    if (mode_q != haw_pkg::MODE_I2C || state_q == haw_pkg::ST_BOOT) begin
      iact_d = 1'b0;
      ackp_d = 1'b0;
      sdoe_n_d = 1'b1;
    end else if (i2c_start) begin
      iact_d = 1'b1;
      ibit_d = '0;
      ackp_d = 1'b0;
      sdoe_n_d = 1'b1;
    end else if (i2c_stop) begin
      iact_d = 1'b0;
      ackp_d = 1'b0;
      sdoe_n_d = 1'b1;
    end else if (iact_q) begin
      if (scl_rise && ibit_q != haw_pkg::I2C_ADDR_BITS) begin
        ish_d = {ish_q[6:0], s2_q.sda};
        ibit_d = ibit_q + 1'b1;
        if (ibit_q + 1'b1 == haw_pkg::I2C_ADDR_BITS) begin
          addr_hit = ish_d[7:1] == I2C_ADDR;
          ackp_d = addr_hit;
          iact_d = addr_hit;
        end
      end
      if (scl_fall && ackp_q) begin
        sdoe_n_d = 1'b0;
        ackp_d = 1'b0;
      end else if (scl_fall && !sdoe_n_q) begin
        sdoe_n_d = 1'b1;
        iact_d = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ish_q <= '0;
      ibit_q <= '0;
      iact_q <= 1'b0;
      ackp_q <= 1'b0;
      sdoe_n_q <= 1'b1;
    end else begin
      ish_q <= ish_d;
      ibit_q <= ibit_d;
      iact_q <= iact_d;
      ackp_q <= ackp_d;
      sdoe_n_q <= sdoe_n_d;
    end
  end

  // attention line: a pending request, or a uart frame in progress
  logic pend_q, pend_d, attn_n_q, attn_n_d, want, serv_ev, req_ev;
  haw_pkg::haw_gap_t gap_q, gap_d;

  assign gap_ok = gap_q == GAP_END;

  always_comb begin
    req_ev = fire_ev | (push_w && mode_q != haw_pkg::MODE_UART
                        && state_q != haw_pkg::ST_BOOT);
    serv_ev = cs_seen | addr_hit;
    // a request landing on the servicing cycle survives it
    pend_d = req_ev ? 1'b1 : (serv_ev ? 1'b0 : pend_q);
    want = (pend_q & ~serv_ev) | uattn_q;
    attn_n_d = attn_n_q;
    gap_d = gap_q;
    if (!attn_n_q) begin
      if (!want) begin
        attn_n_d = 1'b1;
        gap_d = '0;
      end
    end else begin
      if (!gap_ok) begin
        gap_d = gap_q + 1'b1;
      end
      if (want && gap_ok) begin
        attn_n_d = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      pend_q <= 1'b0;
      attn_n_q <= 1'b1;
      gap_q <= '0;
    end else begin
      pend_q <= pend_d;
      attn_n_q <= attn_n_d;
      gap_q <= gap_d;
    end
  end

  assign O_TX_READY = fifo_ready;
  assign O_SPI_MISO = miso_q;
  assign O_SPI_MISO_OE_N = moe_n_q;
  assign O_RX_VALID = rxv_q;
  assign O_RX_DATA = rxd_q;
  assign O_I2C_SDA = 1'b0;
  assign O_I2C_SDA_OE_N = sdoe_n_q;
  assign O_UART_TX = tx_q;
  assign O_AWAKE = awake_q;
  assign O_HOST_ATTENTION_N = attn_n_q;
endmodule

// [dv/haw_host_model.sv]
// host processor model: spi mode 3 master, two-wire addressing master, uart receiver
// assumes the bench calls one task at a time; mosi toggles once at deselect, other link pins stand still between frames
`timescale 1ns/1ps
module haw_host_model (
  input wire logic i_clk,
  input wire logic i_uart_tx,
  input wire logic i_miso,
  input wire logic i_sda_dev,
  input wire logic i_sda_oe_n,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  output logic o_scl,
  output logic o_sda
);
  logic sda_q;
  assign o_sda = sda_q & (i_sda_oe_n | i_sda_dev);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_scl = 1'b1;
    sda_q = 1'b1;
  end
  // 101 ns keeps the link edges off the core clock edges
  task automatic spi_cs(input logic v);
    if (v) #101;
    o_cs_n = v;
    if (!v) #101;
    else o_mosi = ~o_mosi;
  endtask
  task automatic spi_byte(input logic [7:0] mo, output logic [7:0] mi);
    for (int i = 7; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_mosi = mo[i];
      #62.5;
      o_sclk = 1'b1;
      mi[i] = i_miso;
      #62.5;
    end
  endtask
  task automatic i2c_bit(input logic b, output logic s);
    sda_q = b;
    #625;
    o_scl = 1'b1;
    #625;
    s = o_sda;
    #625;
    o_scl = 1'b0;
    #625;
  endtask
  task automatic i2c_addr(input logic [6:0] a, output logic ack);
    logic s;
    sda_q = 1'b0;
    #625;
    o_scl = 1'b0;
    for (int i = 7; i >= 0; i--) i2c_bit(i > 0 ? a[i-1] : 1'b0, s);
    i2c_bit(1'b1, ack);
    sda_q = 1'b0;
    #625;
    o_scl = 1'b1;
    #625;
    sda_q = 1'b1;
    #625;
  endtask
  task automatic uart_rx(output logic [7:0] d, output logic ok);
    int n;
    d = 8'h00;
    for (n = 0; n < 24000 && i_uart_tx !== 1'b0; n++) @(negedge i_clk);
    ok = n < 24000;
    repeat (haw_pkg::BAUD_DIV / 2) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (haw_pkg::BAUD_DIV) @(negedge i_clk);
      d[i] = i_uart_tx;
    end
  endtask
endmodule

// [dv/haw_top_sva.sv]
// checker for haw_top: attention timing and spi, two-wire and uart framing
// assumes it is bound into haw_top and sees only its ports
`timescale 1ns/1ps
module haw_top_sva (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [1:0] I_MODE,
  input wire logic I_SPI_CS_N,
  input wire logic I_I2C_SCL,
  input wire logic O_SPI_MISO_OE_N,
  input wire logic O_RX_VALID,
  input wire logic O_I2C_SDA_OE_N,
  input wire logic O_UART_TX,
  input wire logic O_AWAKE,
  input wire logic O_HOST_ATTENTION_N
);
  // saturating, so a long idle span cannot wrap into a false fail
  logic [15:0] hi_q, hi_d, lo_q, lo_d;
  logic seen_q, seen_d;
  // set from the cycle after this frame's start bit falls, so data-bit falls are not taken as starts
  logic frm_q, frm_d;
  always_comb begin
    hi_d = O_HOST_ATTENTION_N ? hi_q + {15'h0000, ~&hi_q} : 16'h0000;
    lo_d = O_HOST_ATTENTION_N ? 16'h0000 : lo_q + {15'h0000, ~&lo_q};
    seen_d = seen_q | ~O_HOST_ATTENTION_N;
    frm_d = ~O_HOST_ATTENTION_N & (frm_q | ~O_UART_TX);
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      seen_q <= 1'b0;
      frm_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      seen_q <= seen_d;
      frm_q <= frm_d;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_attn_gap_min: assert property ($fell(O_HOST_ATTENTION_N) && seen_q |-> hi_q >= 16'h00c8)
    else $error("attention reasserted too soon");
  a_spi_cs_release: assert property ($fell(I_SPI_CS_N) && !O_HOST_ATTENTION_N && I_MODE == 2'h1
    |-> ##[1:6] O_HOST_ATTENTION_N) else $error("attention not released by chip select");
  a_uart_lead_time: assert property ($fell(O_UART_TX) && !frm_q && I_MODE == 2'h2
    |-> !O_HOST_ATTENTION_N && lo_q >= 16'h0600 && lo_q <= 16'h0608) else $error("bad uart lead");
  a_uart_early_release: assert property ($rose(O_HOST_ATTENTION_N) && I_MODE == 2'h2
    |-> O_UART_TX && lo_q >= 16'h4300 && lo_q <= 16'h4318) else $error("bad uart release");
  a_miso_quiet: assert property (I_SPI_CS_N [*6] |-> O_SPI_MISO_OE_N)
    else $error("miso driven without chip select");
  a_rx_in_frame: assert property (O_RX_VALID |-> I_MODE == 2'h1 && !I_SPI_CS_N ##1 !O_RX_VALID)
    else $error("rx pulse outside a frame");
  a_i2c_ack_low: assert property ($fell(O_I2C_SDA_OE_N) |-> I_MODE == 2'h0 && !I_I2C_SCL)
    else $error("ack driven outside scl low");
  a_wake_attn: assert property ($rose(O_AWAKE) && I_MODE != 2'h2
    |-> ##[0:210] !O_HOST_ATTENTION_N) else $error("no attention after wake");
endmodule
bind haw_top haw_top_sva i_haw_top_sva (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_MODE(I_MODE),
  .I_SPI_CS_N(I_SPI_CS_N), .I_I2C_SCL(I_I2C_SCL), .O_SPI_MISO_OE_N(O_SPI_MISO_OE_N),
  .O_RX_VALID(O_RX_VALID), .O_I2C_SDA_OE_N(O_I2C_SDA_OE_N), .O_UART_TX(O_UART_TX),
  .O_AWAKE(O_AWAKE), .O_HOST_ATTENTION_N(O_HOST_ATTENTION_N));

// [dv/tb_top.sv]
// self-checking bench for haw_top: spi with full fifo, sleep and wake, two-wire, uart
// assumes haw_host_model plays the host and haw_top_sva is bound from its own file
`timescale 1ns/1ps
module tb_top;
  logic clk, reset_n, wake_n, sleep, tx_valid, ok;
  logic [1:0] mode;
  logic [7:0] tx_data, mo, got;
  logic [7:0] fifo_b[4];
  logic [7:0] exp_q[$];
  wire tx_ready, sclk, cs_n, mosi, miso, miso_oe_n, rx_valid, scl, sda, sda_dev, sda_oe_n;
  wire uart_tx, awake, attn_n;
  wire [7:0] rx_data;
  wire miso_line = miso_oe_n ? ~miso : miso;
  int err_count = 0;
  int compares = 0;

  haw_top #(.BOOT_CYC(20), .WAKE_CYC(10)) i_haw_top (.I_CLK(clk), .I_RESET_N(reset_n),
    .I_MODE(mode), .I_WAKE_N(wake_n), .I_SLEEP(sleep), .I_TX_VALID(tx_valid),
    .I_TX_DATA(tx_data), .O_TX_READY(tx_ready), .I_SPI_SCLK(sclk), .I_SPI_CS_N(cs_n),
    .I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .O_SPI_MISO_OE_N(miso_oe_n), .O_RX_VALID(rx_valid),
    .O_RX_DATA(rx_data), .I_I2C_SCL(scl), .I_I2C_SDA(sda), .O_I2C_SDA(sda_dev),
    .O_I2C_SDA_OE_N(sda_oe_n), .O_UART_TX(uart_tx), .O_AWAKE(awake),
    .O_HOST_ATTENTION_N(attn_n));
  haw_host_model i_haw_host_model (.i_clk(clk), .i_uart_tx(uart_tx), .i_miso(miso_line),
    .i_sda_dev(sda_dev), .i_sda_oe_n(sda_oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .o_scl(scl), .o_sda(sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic wait_lvl(input logic which, input logic v, input int bound);
    int n;
    for (n = 0; n < bound && (which ? awake : attn_n) !== v; n++) @(negedge clk);
    if (n == bound) begin
      chk1(which ? awake : attn_n, v);
      wrap_up();
    end
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(negedge clk);
    reset_n = 1'b0;
    mode = m;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
  endtask
  task automatic uart_expect(input logic [7:0] e);
    i_haw_host_model.uart_rx(got, ok);
    if (ok !== 1'b1) begin
      chk1(ok, 1'b1);
      wrap_up();
    end
    chk8(got, e);
  endtask

  // each received spi byte is matched against the oldest byte the host sent
  always @(negedge clk) begin
    if (rx_valid === 1'b1) chk8(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  end

  initial begin
    reset_n = 1'b0;
    mode = 2'h1;
    wake_n = 1'b1;
    sleep = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    void'($urandom(32'h36b3));
    do_reset(2'h1);
    wait_lvl(1'b0, 1'b0, 400);
    @(negedge clk);
    tx_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      fifo_b[i] = 8'($urandom);
      tx_data = fifo_b[i];
      @(negedge clk);
    end
    chk1(tx_ready, 1'b0);
    tx_data = 8'h5a;
    @(negedge clk);
    tx_valid = 1'b0;
    i_haw_host_model.spi_cs(1'b0);
    for (int i = 0; i < 5; i++) begin
      mo = 8'($urandom);
      exp_q.push_back(mo);
      i_haw_host_model.spi_byte(mo, got);
      chk8(got, i < 4 ? fifo_b[i] : haw_pkg::SPI_FILL);
    end
    i_haw_host_model.spi_cs(1'b1);
    chk1(attn_n, 1'b1);
    chk1(exp_q.size() == 0, 1'b1);
    @(negedge clk);
    sleep = 1'b1;
    @(negedge clk);
    sleep = 1'b0;
    repeat (3) @(negedge clk);
    chk1(awake, 1'b0);
    wake_n = 1'b0;
    wait_lvl(1'b1, 1'b1, 40);
    wake_n = 1'b1;
    wait_lvl(1'b0, 1'b0, 300);
    do_reset(2'h0);
    wait_lvl(1'b0, 1'b0, 400);
    i_haw_host_model.i2c_addr(haw_pkg::I2C_ADDR_DEF ^ 7'h01, ok);
    chk1(ok, 1'b1);
    chk1(attn_n, 1'b0);
    i_haw_host_model.i2c_addr(haw_pkg::I2C_ADDR_DEF, ok);
    chk1(ok, 1'b0);
    chk1(attn_n, 1'b1);
    // a queued byte in two-wire mode must raise attention again once the gap is over
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = 8'($urandom);
    @(negedge clk);
    tx_valid = 1'b0;
    wait_lvl(1'b0, 1'b0, 300);
    do_reset(2'h2);
    uart_expect(haw_pkg::ADV_BYTE_DEF);
    mo = 8'($urandom);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = mo;
    @(negedge clk);
    tx_valid = 1'b0;
    uart_expect(mo);
    wrap_up();
  end
endmodule
